// ===== hdl/eti_event_interconnect.sv
// event interconnect: channel routing, configuration unit, wishbone slave
// assumes peripherals, security unit and bus master all run on ref_clk_in
//
// Local design decisions: the address map and the Wishbone register port.
`include "eti_defines.svh"
`default_nettype none

module eti_event_interconnect
    import eti_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [`ETI_ADRW-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic wb_secure_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic [`ETI_NCH-1:0] chan_secure_perm_in,
    input wire logic [`ETI_NPUB-1:0] pub_event_in,
    input wire logic [`ETI_NPUB-1:0] pub_enable_in,
    input wire logic [`ETI_NPUB-1:0] pub_secure_in,
    input wire logic [`ETI_NPUB*`ETI_CHW-1:0] pub_chan_in,
    input wire logic [`ETI_NSUB-1:0] sub_enable_in,
    input wire logic [`ETI_NSUB-1:0] sub_secure_in,
    input wire logic [`ETI_NSUB*`ETI_CHW-1:0] sub_chan_in,
    output logic [`ETI_NSUB-1:0] task_out
);

    // peripheral may use channel: secure side or non-secure channel
    function automatic logic chan_ok(input logic secure, input eti_chmask_type perm,
                                     input eti_chidx_type idx);
        return secure || !perm[idx];
    endfunction

    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // group reachable: secure side or non-secure group
    function automatic logic grp_ok(input logic secure, input logic grp_secure);
        return secure || !grp_secure;
    endfunction

    // address inside a half-open byte window
    function automatic logic in_window(input logic [`ETI_ADRW-1:0] adr,
                                       input logic [`ETI_ADRW-1:0] lo,
                                       input logic [`ETI_ADRW-1:0] hi);
        return (adr >= lo) && (adr < hi);
    endfunction

    eti_bus_state_type bus_state;
    eti_bus_state_type next_bus_state;
    logic ack;
    logic next_ack;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    eti_chmask_type channel_enable_reg;
    eti_chmask_type next_channel_enable_reg;
    eti_chmask_type group_membership_reg [`ETI_NGRP];
    eti_chmask_type next_chg [`ETI_NGRP];
    logic [2*`ETI_NGRP-1:0] gsub_en;
    logic [2*`ETI_NGRP-1:0] next_gsub_en;
    eti_chidx_type gsub_idx [2*`ETI_NGRP];
    eti_chidx_type next_gsub_idx [2*`ETI_NGRP];
    logic [`ETI_NSUB-1:0] tasks;
    logic [`ETI_NSUB-1:0] next_tasks;

    eti_chmask_type pub_hit;
    eti_chmask_type chan_pulse;
    logic [`ETI_NGRP-1:0] gsec;

    // channel side: merge publishers, gate by global enable
    always_comb begin
        pub_hit = '0;
        for (int p = 0; p < `ETI_NPUB; p++) begin
            if (pub_event_in[p] && pub_enable_in[p] &&
                chan_ok(pub_secure_in[p], chan_secure_perm_in,
                        pub_chan_in[p*`ETI_CHW +: `ETI_CHW])) begin
                pub_hit[pub_chan_in[p*`ETI_CHW +: `ETI_CHW]] = 1'b1;
            end
        end
        chan_pulse = pub_hit & channel_enable_reg;
        for (int g = 0; g < `ETI_NGRP; g++) begin
            gsec[g] = |(group_membership_reg[g] & chan_secure_perm_in);
        end
    end

    logic req;
    logic wr_now;
    logic in_task;
    logic in_sub;
    logic in_chg;
    logic [`ETI_ADRW-1:0] sub_off;
    logic [`ETI_ADRW-1:0] chg_off;
    logic [2:0] tg;
    logic [3:0] si;
    logic [2:0] sg;
    logic [2:0] cg;
    logic [31:0] bm;
    logic [31:0] wd;
    eti_chmask_type acc_mask;
    eti_chmask_type cbm;
    eti_chmask_type en_mask;
    eti_chmask_type dis_mask;
    eti_chmask_type c;
    eti_chidx_type ix;
    eti_chidx_type tix;
    logic [31:0] rv;

    // request decode shared by every register group
    always_comb begin
        req = wb_cyc_in && wb_stb_in;
        wr_now = req && (bus_state == ETI_BUS_ACK) && wb_we_in;
        in_task = in_window(wb_adr_in, `ETI_TASK_BASE, `ETI_TASK_END);
        in_sub = in_window(wb_adr_in, `ETI_SUB_BASE, `ETI_SUB_END);
        in_chg = in_window(wb_adr_in, `ETI_CHG_BASE, `ETI_CHG_END);
        sub_off = wb_adr_in - `ETI_SUB_BASE;
        chg_off = wb_adr_in - `ETI_CHG_BASE;
        tg = wb_adr_in[5:3];
        si = sub_off[6:3] * 4'h2 + {3'h0, sub_off[2]};
        sg = sub_off[5:3];
        cg = chg_off[4:2];
        bm = byte_mask(wb_sel_in);
        wd = wb_dat_in & bm;
        cbm = bm[`ETI_NCH-1:0];
        acc_mask = wb_secure_in ? '1 : ~chan_secure_perm_in;
    end

    // peripheral tasks: one cycle pulse per subscribed channel pulse
    always_comb begin
        next_tasks = '0;
        tix = '0;
        // subscribers see their channel one cycle after the event
        for (int s = 0; s < `ETI_NSUB; s++) begin
            tix = sub_chan_in[s*`ETI_CHW +: `ETI_CHW];
            next_tasks[s] = sub_enable_in[s] && chan_pulse[tix] &&
                            chan_ok(sub_secure_in[s], chan_secure_perm_in, tix);
        end
    end

    // group enable and disable masks from channels and software
    always_comb begin
        en_mask = '0;
        dis_mask = '0;
        ix = '0;
        // channel-fired group tasks; non-secure channels skip secure groups
        for (int g = 0; g < `ETI_NGRP; g++) begin
            ix = gsub_idx[2*g];
            if (gsub_en[2*g] && chan_pulse[ix] &&
                grp_ok(chan_secure_perm_in[ix], gsec[g])) begin
                en_mask = en_mask | group_membership_reg[g];
            end
            ix = gsub_idx[2*g+1];
            if (gsub_en[2*g+1] && chan_pulse[ix] &&
                grp_ok(chan_secure_perm_in[ix], gsec[g])) begin
                dis_mask = dis_mask | group_membership_reg[g];
            end
        end
        // software task writes
        if (wr_now && in_task && wd[`ETI_TASK_BIT] &&
            grp_ok(wb_secure_in, gsec[tg])) begin
            if (wb_adr_in[2]) begin
                dis_mask = dis_mask | group_membership_reg[tg];
            end else begin
                en_mask = en_mask | group_membership_reg[tg];
            end
        end

    end

    // individual enable registers, secure bits masked for non-secure
    always_comb begin
        c = channel_enable_reg;
        // software writes first, then group disable, group enable last
        if (wr_now && wb_adr_in == `ETI_CHANNEL_ENABLE_REG) begin
            c = (c & ~(acc_mask & cbm)) | (wd[`ETI_NCH-1:0] & acc_mask);
        end
        if (wr_now && wb_adr_in == `ETI_CHANNEL_ENABLE_REG_SET) begin
            c = c | (wd[`ETI_NCH-1:0] & acc_mask);
        end
        if (wr_now && wb_adr_in == `ETI_CHANNEL_ENABLE_REG_CLR) begin
            c = c & ~(wd[`ETI_NCH-1:0] & acc_mask);
        end
        next_channel_enable_reg = (c & ~dis_mask) | en_mask;

    end

    // membership registers, locked while either group task is subscribed
    always_comb begin
        next_chg = group_membership_reg;
        if (wr_now && in_chg && !gsub_en[2*cg] && !gsub_en[2*cg+1] &&
            grp_ok(wb_secure_in, gsec[cg])) begin
            next_chg[cg] = (group_membership_reg[cg] & ~(acc_mask & cbm)) |
                           (wd[`ETI_NCH-1:0] & acc_mask);
        end

    end

    // group task subscriptions
    always_comb begin
        next_gsub_en = gsub_en;
        next_gsub_idx = gsub_idx;
        // lane 3 carries the enable bit, lane 0 the channel index
        if (wr_now && in_sub && grp_ok(wb_secure_in, gsec[sg])) begin
            if (bm[`ETI_SUB_EN_BIT]) begin
                next_gsub_en[si] = wd[`ETI_SUB_EN_BIT];
            end
            if (bm[0]) begin
                next_gsub_idx[si] = wd[`ETI_CHW-1:0];
            end
        end

    end

    // read mux, blocked fields read zero
    always_comb begin
        rv = 32'h0000_0000;
        if (wb_adr_in == `ETI_CHANNEL_ENABLE_REG || wb_adr_in == `ETI_CHANNEL_ENABLE_REG_SET ||
            wb_adr_in == `ETI_CHANNEL_ENABLE_REG_CLR) begin
            rv[`ETI_NCH-1:0] = channel_enable_reg & acc_mask;
        end else if (in_chg && grp_ok(wb_secure_in, gsec[cg])) begin
            rv[`ETI_NCH-1:0] = group_membership_reg[cg];
        end else if (in_sub && grp_ok(wb_secure_in, gsec[sg])) begin
            rv[`ETI_SUB_EN_BIT] = gsub_en[si];
            rv[`ETI_CHW-1:0] = gsub_idx[si];
        end

    end

    // single-cycle acknowledge, never an error
    always_comb begin
        next_bus_state = bus_state;
        next_ack = ack;
        next_rdata = rdata;
        // writes commit on the edge that ends the ack cycle
        unique case (bus_state)
            ETI_BUS_IDLE: begin
                if (req) begin
                    next_bus_state = ETI_BUS_ACK;
                    next_ack = 1'b1;
                    next_rdata = rv;
                end
            end
            ETI_BUS_ACK: begin
                next_bus_state = ETI_BUS_IDLE;
                next_ack = 1'b0;
            end
        endcase
    end

    // all state below freezes while clk_en_in is low
    // bus handshake and read data
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bus_state <= ETI_BUS_IDLE;
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end else if (clk_en_in) begin
            bus_state <= next_bus_state;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    // global channel enables
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            channel_enable_reg <= `ETI_CHANNEL_ENABLE_REG_RST;
        end else if (clk_en_in) begin
            channel_enable_reg <= next_channel_enable_reg;
        end
    end

    // group membership
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int g = 0; g < `ETI_NGRP; g++) begin
                group_membership_reg[g] <= `ETI_CHG_RST;
            end
        end else if (clk_en_in) begin
            group_membership_reg <= next_chg;
        end
    end

    // group task subscriptions
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gsub_en <= '0;
            for (int k = 0; k < 2*`ETI_NGRP; k++) begin
                gsub_idx[k] <= `ETI_SUB_IDX_RST;
            end
        end else if (clk_en_in) begin
            gsub_en <= next_gsub_en;
            gsub_idx <= next_gsub_idx;
        end
    end

    // peripheral task pulses
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tasks <= '0;
        end else if (clk_en_in) begin
            tasks <= next_tasks;
        end
    end

    assign wb_ack_out = ack;
    assign wb_dat_out = rdata;
    assign task_out = tasks;

endmodule // eti_event_interconnect

`default_nettype wire

// ===== hdl/eti_defines.svh
// constants of the event and task channel interconnect
// assumes inclusion by eti_pkg and the design file only
`ifndef ETI_DEFINES_SVH
`define ETI_DEFINES_SVH

// sizes
`define ETI_NCH 16
`define ETI_CHW 4
`define ETI_NGRP 6
`define ETI_NPUB 8
`define ETI_NSUB 8
`define ETI_ADRW 12

// register byte offsets
`define ETI_TASK_BASE 12'h000
`define ETI_TASK_END 12'h030
`define ETI_SUB_BASE 12'h080
`define ETI_SUB_END 12'h0b0
`define ETI_CHANNEL_ENABLE_REG 12'h500
`define ETI_CHANNEL_ENABLE_REG_SET 12'h504
`define ETI_CHANNEL_ENABLE_REG_CLR 12'h508
`define ETI_CHG_BASE 12'h800
`define ETI_CHG_END 12'h818

// field positions
`define ETI_SUB_EN_BIT 31
`define ETI_TASK_BIT 0

// reset values
`define ETI_CHANNEL_ENABLE_REG_RST 16'h0000
`define ETI_CHG_RST 16'h0000
`define ETI_SUB_IDX_RST 4'h0

`endif

// ===== hdl/eti_pkg.sv
// types of the event and task channel interconnect
// assumes eti_defines.svh on the include path
`include "eti_defines.svh"
`default_nettype none

package eti_pkg;
    typedef logic [`ETI_NCH-1:0] eti_chmask_type;
    typedef logic [`ETI_CHW-1:0] eti_chidx_type;
    typedef enum logic [1:0] {
        ETI_BUS_IDLE = 2'b01,
        ETI_BUS_ACK = 2'b10
    } eti_bus_state_type;
endpackage

`default_nettype wire

// ===== test/eti_checker.sv
// checker: bus handshake and task routing relations at the block ports
// assumes bind onto eti_event_interconnect with clk_en_in held high
`default_nettype none
module eti_checker (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic [15:0] chan_secure_perm_in,
    input wire logic [7:0] pub_event_in,
    input wire logic [7:0] sub_enable_in,
    input wire logic [7:0] sub_secure_in,
    input wire logic [31:0] sub_chan_in,
    input wire logic [7:0] task_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] blk;
    logic same01;
    // non-secure subscriber parked on a secure channel
    always_comb begin
        for (int s = 0; s < 8; s++) begin
            blk[s] = !sub_secure_in[s] && chan_secure_perm_in[sub_chan_in[4*s+:4]];
        end
    end
    assign same01 = &sub_enable_in[1:0] && &sub_secure_in[1:0]
        && sub_chan_in[3:0] == sub_chan_in[7:4];
    default clocking dc @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence s_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence s_ack_pulse;
        wb_ack_out ##1 !wb_ack_out;
    endsequence
    a_ack_answer: assert property (s_req |=> s_ack_pulse)
        else $error("ack not one cycle after request");
    a_ack_cause: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in) && $past(wb_stb_in))
        else $error("ack without request");
    a_ack_drop: assert property (!wb_cyc_in |=> !wb_ack_out)
        else $error("ack while idle");
    a_dat_hold: assert property (!wb_ack_out |-> $stable(wb_dat_out))
        else $error("read data moved without ack");
    a_task_sub: assert property ((task_out & ~$past(sub_enable_in)) == 8'h00)
        else $error("task from disabled subscription");
    a_task_event: assert property (pub_event_in == 8'h00 |=> task_out == 8'h00)
        else $error("task without event");
    a_task_secure: assert property ((task_out & $past(blk)) == 8'h00)
        else $error("non-secure task on secure channel");
    a_task_fanout: assert property ($past(same01) |-> task_out[0] == task_out[1])
        else $error("fan-out mismatch");
endmodule // eti_checker

bind eti_event_interconnect eti_checker CHK (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .chan_secure_perm_in(chan_secure_perm_in),
    .pub_event_in(pub_event_in), .sub_enable_in(sub_enable_in),
    .sub_secure_in(sub_secure_in), .sub_chan_in(sub_chan_in), .task_out(task_out));
`default_nettype wire

// ===== test/eti_periph_model.sv
// peripheral side: eight publishers and eight subscribers
// assumes the bench calls its tasks from clocked test code
`default_nettype none
module eti_periph_model (
    input wire logic clk_in,
    output logic [7:0] ev_out,
    output logic [7:0] pen_out,
    output logic [7:0] psec_out,
    output logic [31:0] pch_out,
    output logic [7:0] sen_out,
    output logic [7:0] ssec_out,
    output logic [31:0] sch_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {ev_out, pen_out, psec_out, pch_out, sen_out, ssec_out, sch_out} = '0;
    task automatic cfg(input logic sb, input int i, input logic e, input logic s,
        input logic [3:0] c);
        @(posedge clk_in);
        if (sb) begin
            sen_out[i] <= e;
            ssec_out[i] <= s;
            sch_out[4*i+:4] <= c;
        end else begin
            pen_out[i] <= e;
            psec_out[i] <= s;
            pch_out[4*i+:4] <= c;
        end
    endtask
    // one-cycle event pulse
    task automatic fire(input logic [7:0] m);
        @(posedge clk_in);
        ev_out <= m;
        @(posedge clk_in);
        ev_out <= 8'h00;
    endtask
endmodule // eti_periph_model
`default_nettype wire

// ===== test/eti_event_interconnect_test.sv
// bench: register, routing and group tests of the event interconnect
// assumes checker bind and peripheral model are compiled before it
`default_nettype none
module eti_event_interconnect_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic S = 1'b1, N = 1'b0;
    logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, sec = 1'b0, ack;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0, rdat, rq, pch, sch;
    logic [7:0] ev, pen, psec, sen, ssec, tsk;
    eti_pkg::eti_chmask_type perm = 16'h0001;
    int err_count = 0, checked = 0;
    always #5 clk = ~clk;
    eti_periph_model PM (.clk_in(clk), .ev_out(ev), .pen_out(pen), .psec_out(psec),
        .pch_out(pch), .sen_out(sen), .ssec_out(ssec), .sch_out(sch));
    eti_event_interconnect DUT (.ref_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(1'b1),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
        .wb_dat_in(wdat), .wb_secure_in(sec), .wb_dat_out(rdat), .wb_ack_out(ack),
        .chan_secure_perm_in(perm), .pub_event_in(ev), .pub_enable_in(pen),
        .pub_secure_in(psec), .pub_chan_in(pch), .sub_enable_in(sen),
        .sub_secure_in(ssec), .sub_chan_in(sch), .task_out(tsk));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic s, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, sec, adr, wdat} <= {2'b11, w, s, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        rq = rdat;
        chk(32'(n), 32'h2);
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wr(input logic s, input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, s, a, d);
    endtask
    task automatic rd(input logic s, input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, s, a, 32'h0);
        chk(rq, e);
    endtask
    task automatic fire(input logic [7:0] m, input logic [7:0] e);
        PM.fire(m);
        @(negedge clk);
        chk({24'h0, tsk}, {24'h0, e});
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd(S, 12'h500, 32'h0);
        rd(S, 12'h800, 32'h0);
        rd(S, 12'h400, 32'h0);
        wr(S, 12'h504, 32'hff);
        wr(S, 12'h508, 32'h03);
        rd(S, 12'h504, 32'hfc);
        wr(S, 12'h500, 32'h0f);
        rd(N, 12'h508, 32'h0e);
        wr(N, 12'h508, 32'h0f);
        rd(S, 12'h500, 32'h01);
        wr(S, 12'h504, 32'h0e);
        $display("test registers done");
        PM.cfg(N, 0, S, N, 4'h1);
        PM.cfg(N, 1, S, S, 4'h1);
        PM.cfg(N, 2, N, S, 4'h1);
        PM.cfg(N, 3, S, N, 4'h0);
        PM.cfg(N, 4, S, S, 4'h4);
        PM.cfg(S, 0, S, S, 4'h1);
        PM.cfg(S, 1, S, S, 4'h1);
        PM.cfg(S, 3, S, S, 4'h0);
        PM.cfg(S, 5, S, N, 4'h0);
        PM.cfg(S, 6, N, S, 4'h1);
        fire(8'h03, 8'h03);
        fire(8'h01, 8'h03);
        fire(8'h04, 8'h00);
        fire(8'h08, 8'h00);
        fire(8'h10, 8'h00);
        PM.cfg(N, 3, S, S, 4'h0);
        fire(8'h08, 8'h08);
        $display("test routing done");
        for (int n = 0; n < 6; n++) begin
            wr(S, 12'h800 + 12'(4 * n), 32'h100 << n);
            wr(S, 12'(8 * n), 32'h1);
            rd(S, 12'h500, 32'h0f | (32'h100 << n));
            wr(S, 12'(8 * n + 4), 32'h1);
            rd(S, 12'h500, 32'h0f);
        end
        wr(S, 12'h804, 32'h100);
        wr(S, 12'h080, 32'h8000_0001);
        wr(S, 12'h08c, 32'h8000_0001);
        fire(8'h01, 8'h03);
        rd(S, 12'h500, 32'h10f);
        wr(S, 12'h800, 32'h0);
        rd(S, 12'h800, 32'h100);
        wr(S, 12'h08c, 32'h0);
        wr(S, 12'h808, 32'h401);
        rd(N, 12'h808, 32'h0);
        wr(N, 12'h010, 32'h1);
        wr(S, 12'h090, 32'h8000_0001);
        fire(8'h01, 8'h03);
        rd(S, 12'h500, 32'h10f);
        wr(S, 12'h098, 32'h8000_0000);
        wr(S, 12'h090, 32'h8000_0000);
        fire(8'h08, 8'h08);
        rd(S, 12'h500, 32'hd0f);
        $display("test groups done");
        print_verdict();
    end
endmodule // eti_event_interconnect_test
`default_nettype wire
